//--- rtl/eleb_top.sv
/*
  Error log entry builder: captures error reports into 64-byte log
  entries, keeps a persistent error count, answers health log requests
  and raises critical-warning events. Software reaches it over AXI4-Lite.
  Assumes error and warning inputs come from logic on aclk, and that a
  keeper outside saves persist_count and restores it after power-up.
*/
// Notes on behaviour
// - Count starts at one, increments per entry.
// - Count survives power off via restore.
// - Zero count marks invalid or absent entries.
// - Queue identifier, all ones without command.
// - Command tag, all ones without command.
// - Status bits fifteen to one, phase bit zero.
// - Commandless error carries best fitting status.
// - Location byte and bit, else all ones.
// - Multi-byte parameter reports first byte, bit.
// - First affected block address in bytes 23:16.
// - Associated namespace in bytes 27:24.
// - Vendor page zero or 80h to FFh.
// - Command specific data in bytes 39:32.
// - Log is 64-byte entries up to maximum.
// - Newest error returned as first entry.
// - Full log drops oldest for newest.
// - Reset empties the whole log.
// - Health data is lifetime and persistent.
// - Attribute bit zero advertises per-namespace health.
// - Unsupported namespace aborts with invalid field.
// - Not aborting returns controller-wide health log.
// - Enabled critical warnings raise an event.
`timescale 1ns/1ps
module eleb_top
  import eleb_pkg::*;
#(
  parameter int unsigned DEPTH = 16,
  parameter bit PER_NS = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [eleb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [eleb_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [eleb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [eleb_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic err_valid,
  input wire logic err_for_cmd,
  input wire logic [15:0] err_source_queue_identifier,
  input wire logic [15:0] err_failing_command_tag,
  input wire logic [14:0] err_status,
  input wire logic err_phase,
  input wire logic [5:0] err_param_byte,
  input wire logic [2:0] err_param_bit,
  input wire logic [63:0] err_lba,
  input wire logic [31:0] err_nsid,
  input wire logic [7:0] err_vendor_page,
  input wire logic [63:0] err_cmd_info,
  input wire logic count_restore,
  input wire logic [63:0] count_restore_value,
  input wire logic [7:0] crit_warn,
  output logic [63:0] persist_count,
  output logic async_event
);
  import eleb_pkg::*;

  // Log depth must fit the 8-bit entry selector and the store.
  if (DEPTH < 2 || DEPTH > 256) begin : g_bad_depth
    $error("eleb_top: DEPTH must lie in 2..256");
  end

  // All state of the builder.
  typedef struct packed {
    logic awready; // Write address and data taken together.
    logic bvalid; // Write response pending.
    logic [1:0] bresp; // Write response code.
    logic arready; // Read address taken.
    logic rvalid; // Read data pending.
    logic [1:0] rresp; // Read response code.
    logic [31:0] rdata; // Read data.
    logic abort_ns; // Abort unsupported namespace requests.
    logic [7:0] sel; // Entry selected for the window.
    logic [3:0] hres; // Last health request outcome.
    logic [7:0] warn_en; // Enabled warning types.
    logic [7:0] warn_flags; // Sticky raised warnings.
    logic [7:0] warn_prev; // Warning levels one cycle ago.
    logic event_o; // Event pulse.
    logic [63:0] count; // Last issued error count.
  } eleb_top_st_t;

  eleb_top_st_t s_q;
  eleb_top_st_t s_d;

  eleb_log_if lg ();

  // Entry ring; deep enough to hold the advertised maximum.
  eleb_store #(
    .DEPTH(DEPTH)
  ) u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .lg(lg)
  );

  // Byte-lane merge of a bus write into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // One 32-bit word of a 64-byte entry image.
  function automatic logic [31:0] entry_word(input eleb_entry_t e, input logic [3:0] w);
    logic [31:0] r;
    case (w)
      4'h0: r = e.count[31:0];
      4'h1: r = e.count[63:32];
      4'h2: r = {e.tag, e.sqid};
      4'h3: r = {e.pel, e.status};
      4'h4: r = e.lba[31:0];
      4'h5: r = e.lba[63:32];
      4'h6: r = e.nsid;
      4'h7: r = {24'h000000, e.vpage};
      4'h8: r = e.cmdinfo[31:0];
      4'h9: r = e.cmdinfo[63:32];
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction : entry_word

  // Combinational working values.
  logic [63:0] count_base; // Count before this cycle's error.
  logic [7:0] warn_rise; // Newly raised, enabled warnings.
  logic [7:0] warn_clr; // Software clear mask.
  eleb_entry_t ent; // Entry being built.
  logic [31:0] rd_word; // Word chosen by the read address.
  logic rd_ok; // Read address is mapped.
  logic [31:0] wr_cur; // Current value of a writable register.
  logic [31:0] wr_new; // Merged write value.
  logic [31:0] req_nsid; // Namespace of a health request.

  // Entry construction from the error report.
  always_comb begin
    count_base = count_restore ? count_restore_value : s_q.count;
    ent = '0;
    ent.count = count_base + 64'h1;
    ent.status = {err_status, err_phase};
    ent.lba = err_lba;
    ent.nsid = err_nsid;
    ent.cmdinfo = err_cmd_info;
    ent.vpage = (err_vendor_page >= VPAGE_MIN) ? err_vendor_page : VPAGE_NONE;
    if (err_for_cmd) begin
      ent.sqid = err_source_queue_identifier;
      ent.tag = err_failing_command_tag;
      ent.pel = {PEL_RSVD, err_param_bit, 2'b00, err_param_byte};
    end else begin
      ent.sqid = NO_CMD_ID;
      ent.tag = NO_CMD_ID;
      ent.pel = NO_CMD_ID;
    end
    lg.wr_valid = err_valid;
    lg.wr_entry = ent;
    lg.rd_idx = s_q.sel;
  end

  // Read decode; the entry window fills the map from A_WIN_BASE upward.
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    if (s_axi_araddr >= A_WIN_BASE) begin
      if (lg.rd_hit) begin
        rd_word = entry_word(lg.rd_entry, s_axi_araddr[5:2]);
      end
    end else begin
      case (s_axi_araddr)
        A_CTRL: rd_word = {31'h0, s_q.abort_ns};
        A_ENTRY_SEL: rd_word = {24'h0, s_q.sel};
        A_LOG_STATUS: rd_word = {16'(DEPTH), lg.fill};
        A_LOG_ATTR: rd_word = {31'h0, PER_NS};
        A_HEALTH_RESULT: rd_word = {28'h0, s_q.hres};
        A_WARN_EN: rd_word = {24'h0, s_q.warn_en};
        A_WARN_FLAGS: rd_word = {24'h0, s_q.warn_flags};
        A_LIFE_LO: rd_word = s_q.count[31:0];
        A_LIFE_HI: rd_word = s_q.count[63:32];
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Current value of the addressed writable register for lane merging.
  always_comb begin
    case (s_axi_awaddr)
      A_CTRL: wr_cur = {31'h0, s_q.abort_ns};
      A_ENTRY_SEL: wr_cur = {24'h0, s_q.sel};
      A_WARN_EN: wr_cur = {24'h0, s_q.warn_en};
      default: wr_cur = 32'h00000000;
    endcase
    wr_new = merge(wr_cur, s_axi_wdata, s_axi_wstrb);
    // A health request uses all lanes; partial namespace writes are unusual.
    req_nsid = wr_new;
  end

  // Main next-state logic.
  always_comb begin
    s_d = s_q;
    s_d.event_o = 1'b0;
    warn_clr = 8'h00;

    // Error counting; numbering persists through the outside keeper.
    s_d.count = count_base;
    if (err_valid) begin
      s_d.count = ent.count;
    end

    // Write channel: both address and data must be offered, then one
    // cycle of ready takes them together.
    s_d.awready = s_axi_awvalid && s_axi_wvalid && !s_q.awready && !s_q.bvalid;
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.awready) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_axi_awaddr)
        A_CTRL: s_d.abort_ns = wr_new[0];
        A_ENTRY_SEL: s_d.sel = wr_new[7:0];
        A_WARN_EN: s_d.warn_en = wr_new[7:0];
        A_WARN_FLAGS: warn_clr = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        A_HEALTH_NSID: begin
          s_d.hres = 4'h0;
          s_d.hres[HR_DONE] = 1'b1;
          if (req_nsid == NSID_ALL || req_nsid == NSID_NONE) begin
            s_d.hres[HR_CTRL_LOG] = 1'b1;
          end else if (PER_NS) begin
            s_d.hres[HR_NS_LOG] = 1'b1;
          end else if (s_q.abort_ns) begin
            s_d.hres[HR_INVALID] = 1'b1;
          end else begin
            s_d.hres[HR_CTRL_LOG] = 1'b1;
          end
        end
        A_LOG_STATUS, A_LOG_ATTR, A_HEALTH_RESULT, A_LIFE_LO, A_LIFE_HI: begin
          // Read-only registers ignore writes but answer normally.
          s_d.bresp = RESP_OKAY;
        end
        default: begin
          // The entry window is read-only as well.
          s_d.bresp = (s_axi_awaddr >= A_WIN_BASE) ? RESP_OKAY : RESP_SLVERR;
        end
      endcase
    end

    // Read channel: take the address, answer on the following cycle.
    s_d.arready = s_axi_arvalid && !s_q.arready && !s_q.rvalid;
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    s_d.warn_prev = crit_warn;
    warn_rise = crit_warn & ~s_q.warn_prev & s_q.warn_en;
    // A new warning wins over a clear landing in the same cycle.
    s_d.warn_flags = (s_q.warn_flags & ~warn_clr) | warn_rise;
    s_d.event_o = |warn_rise;

    if (!aresetn) begin
      s_d = '0;
      s_d.abort_ns = CTRL_ABORT_RESET;
      s_d.count = count_base;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // Outputs straight from state flops.
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.awready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign persist_count = s_q.count;
  assign async_event = s_q.event_o;

endmodule : eleb_top

//--- rtl/eleb_pkg.sv
/*
  Shared constants and types of the error log entry builder: register map,
  entry layout, field constants and reset values.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package eleb_pkg;

  // Bus widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ENTRY_SEL = 8'h04;
  localparam logic [7:0] A_LOG_STATUS = 8'h08;
  localparam logic [7:0] A_LOG_ATTR = 8'h0c;
  localparam logic [7:0] A_HEALTH_NSID = 8'h10;
  localparam logic [7:0] A_HEALTH_RESULT = 8'h14;
  localparam logic [7:0] A_WARN_EN = 8'h18;
  localparam logic [7:0] A_WARN_FLAGS = 8'h1c;
  localparam logic [7:0] A_LIFE_LO = 8'h20;
  localparam logic [7:0] A_LIFE_HI = 8'h24;
  localparam logic [7:0] A_WIN_BASE = 8'h40;

  // Entry window: 16 words of 4 bytes make one 64-byte entry.
  localparam int unsigned ENTRY_WORDS = 16;

  // Field constants.
  localparam logic [15:0] NO_CMD_ID = 16'hffff;
  localparam logic [31:0] NSID_ALL = 32'hffffffff;
  localparam logic [31:0] NSID_NONE = 32'h00000000;
  localparam logic [7:0] VPAGE_MIN = 8'h80;
  localparam logic [7:0] VPAGE_NONE = 8'h00;
  localparam logic [4:0] PEL_RSVD = 5'h00;
  localparam logic [63:0] COUNT_RESET = 64'h0;

  // Reset values and response codes.
  localparam logic CTRL_ABORT_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Health result bit positions.
  localparam int unsigned HR_DONE = 0;
  localparam int unsigned HR_INVALID = 1;
  localparam int unsigned HR_CTRL_LOG = 2;
  localparam int unsigned HR_NS_LOG = 3;

  // One stored entry; the reserved bytes are not stored and read as zero.
  typedef struct packed {
    logic [63:0] count;
    logic [15:0] sqid;
    logic [15:0] tag;
    logic [15:0] status;
    logic [15:0] pel;
    logic [63:0] lba;
    logic [31:0] nsid;
    logic [7:0] vpage;
    logic [63:0] cmdinfo;
  } eleb_entry_t;

endpackage : eleb_pkg

//--- rtl/eleb_log_if.sv
/*
  Carrier between the entry builder and the entry store: one write port
  and one combinational read port by age index.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface eleb_log_if;
  import eleb_pkg::*;

  logic wr_valid; // Store a new entry this cycle.
  eleb_entry_t wr_entry; // Entry to store.
  logic [7:0] rd_idx; // Age index, zero is the newest.
  eleb_entry_t rd_entry; // Entry at that index.
  logic rd_hit; // Index lies below the fill level.
  logic [15:0] fill; // Number of valid entries.

  modport builder (output wr_valid, output wr_entry, output rd_idx,
                   input rd_entry, input rd_hit, input fill);
  modport store (input wr_valid, input wr_entry, input rd_idx,
                 output rd_entry, output rd_hit, output fill);
endinterface : eleb_log_if

//--- rtl/eleb_store.sv
/*
  Ring store of error log entries with newest-first read by age index.
  Assumes one writer on the same clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module eleb_store #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  eleb_log_if.store lg
);
  import eleb_pkg::*;

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // The age index is 8 bits wide, so deeper stores could not be read.
  if (DEPTH < 2 || DEPTH > 256) begin : g_bad_depth
    $error("eleb_store: DEPTH must lie in 2..256");
  end

  // All state of the store.
  typedef struct packed {
    eleb_entry_t [DEPTH-1:0] slot; // Entry array.
    logic [PW-1:0] wptr; // Next slot to write.
    logic [15:0] fill; // Valid entries.
  } eleb_store_st_t;

  eleb_store_st_t s_q;
  eleb_store_st_t s_d;
  logic [PW-1:0] rd_slot; // Physical slot of the requested age.

  // Next-state logic for writes.
  always_comb begin
    s_d = s_q;
    if (lg.wr_valid) begin
      s_d.slot[s_q.wptr] = lg.wr_entry;
      s_d.wptr = (s_q.wptr == PW'(DEPTH - 1)) ? '0 : s_q.wptr + PW'(1);
      if (s_q.fill != 16'(DEPTH)) begin
        s_d.fill = s_q.fill + 16'h0001;
      end
    end
    if (!aresetn) begin
      s_d.wptr = '0;
      s_d.fill = 16'h0000;
    end
  end

  // State register; slot contents need no reset since fill hides them.
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  always_comb begin
    rd_slot = s_q.wptr - PW'(1) - PW'(lg.rd_idx);
    if ({1'b0, s_q.wptr} < {1'b0, PW'(1)} + {1'b0, PW'(lg.rd_idx)}) begin
      rd_slot = PW'(DEPTH) + rd_slot;
    end
    lg.rd_hit = 16'(lg.rd_idx) < s_q.fill;
    lg.rd_entry = s_q.slot[rd_slot];
    lg.fill = s_q.fill;
  end

endmodule : eleb_store

//--- verif/eleb_props.sv
/*
  Checker of the error log entry builder, watching the top ports only.
  Assumes one clock, a synchronous active-low reset and the bind below.
*/
`timescale 1ns/1ps
module eleb_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic err_valid,
  input wire logic count_restore,
  input wire logic [63:0] count_restore_value,
  input wire logic [7:0] crit_warn,
  input wire logic [63:0] persist_count,
  input wire logic async_event
);
  // All checks share the one clock; reset masks all but the reset check.
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_count_step: assert property (err_valid && !count_restore |=>
    persist_count == $past(persist_count) + 64'h1) else $error("count did not step by one");
  a_count_hold: assert property (!err_valid && !count_restore |=>
    $stable(persist_count)) else $error("count moved without an error");
  a_restore_load: assert property (count_restore |=>
    persist_count == $past(count_restore_value) + 64'($past(err_valid)))
    else $error("restored count not loaded");
  a_write_accept: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    && !s_axi_awready |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
    else $error("write not taken or answered in time");
  a_read_accept: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready ##1 s_axi_rvalid) else $error("read not taken or answered in time");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  // An event needs a warning line that went high one cycle before.
  a_event_cause: assert property (async_event |->
    ($past(crit_warn) & ~$past(crit_warn, 2)) != 8'h0) else $error("event without rise");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !async_event) else $error("outputs live in reset");
endmodule : eleb_props

bind eleb_top eleb_props i_props (.*);

//--- verif/eleb_host.sv
/*
  Host software model: an AXI4-Lite master issuing one register access at a time.
  Assumes its tasks are called just after a rising edge of aclk.
*/
`timescale 1ns/1ps
module eleb_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int lag = 0; // Cycles before the answer is taken, to model a slow host.

  // Idle bus at time zero; all byte lanes are always written.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
  end

  // One write: address and data together, held until taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // Released lines show the inverse so stale values never look live.
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    repeat (lag) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // One read, answer taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (lag) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : eleb_host

//--- verif/testbench.sv
/*
  Self-checking bench of the error log entry builder with a host model.
  Assumes the package constants and a small ring depth to reach overflow.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import eleb_pkg::*;
  localparam int unsigned DEPTH = 4; // Small ring so that overflow comes quickly.
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, err_vendor_page, crit_warn;
  logic [2:0] s_axi_awprot, s_axi_arprot, err_param_bit;
  logic [31:0] s_axi_wdata, s_axi_rdata, err_nsid;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic err_valid, err_for_cmd, err_phase, count_restore, async_event;
  logic [15:0] err_source_queue_identifier, err_failing_command_tag;
  logic [14:0] err_status;
  logic [5:0] err_param_byte;
  logic [63:0] err_lba, err_cmd_info, count_restore_value, persist_count, ecnt;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  integer seed = 32'hecf7;
  eleb_entry_t q[$]; // Expected entries, newest first.
  logic [31:0] hn[4] = '{NSID_NONE, NSID_ALL, 32'h5, 32'h5}; // Health requests.
  logic [31:0] hr[4] = '{32'h5, 32'h5, 32'h3, 32'h5}; // Expected health results.

  eleb_top #(.DEPTH(DEPTH), .PER_NS(1'b0)) i_dut (.*);
  eleb_host i_host (.*);

  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // A hang is cut short and counted as a mismatch.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // Word w of an entry as the window presents it; unused words read zero.
  function automatic logic [31:0] exp_word(eleb_entry_t e, int w);
    case (w)
      0: return e.count[31:0];
      1: return e.count[63:32];
      2: return {e.tag, e.sqid};
      3: return {e.pel, e.status};
      4: return e.lba[31:0];
      5: return e.lba[63:32];
      6: return e.nsid;
      7: return {24'h0, e.vpage};
      8: return e.cmdinfo[31:0];
      9: return e.cmdinfo[63:32];
      default: return 32'h0;
    endcase
  endfunction : exp_word

  task automatic wreg(logic [7:0] a, logic [31:0] d, logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    i_host.lag = $random(seed) & 3;
    i_host.wr(a, d, r);
    `CHK(r, er)
  endtask : wreg

  task automatic rchk(logic [7:0] a, logic [31:0] e, logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    i_host.lag = $random(seed) & 3;
    i_host.rd(a, d, r);
    `CHK({r, d}, {er, e})
  endtask : rchk

  // Reads every slot plus one past the ring; slots beyond the fill read zero.
  task automatic check_log();
    int n;
    while (q.size() > DEPTH) begin
      q.pop_back();
    end
    n = q.size();
    rchk(A_LOG_STATUS, {16'(DEPTH), 16'(n)});
    for (int i = 0; i <= DEPTH; i++) begin
      wreg(A_ENTRY_SEL, 32'(i));
      for (int w = 0; w < ENTRY_WORDS; w++) begin
        if (i < n) begin
          rchk(A_WIN_BASE + 8'(4 * w), exp_word(q[i], w));
        end else begin
          rchk(A_WIN_BASE + 8'(4 * w), 32'h0);
        end
      end
    end
  endtask : check_log

  // Back-to-back random errors; the first is commandless, the second a boundary.
  task automatic add_errs(int n);
    logic [255:0] r;
    eleb_entry_t e;
    for (int k = 0; k < n; k++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed),
           $random(seed), $random(seed), $random(seed), $random(seed)};
      r[57] = (k == 0) ? 1'b0 : r[57];
      r[71:48] = (k == 1) ? {8'h80, 6'h00, 1'b1, 3'h7, 6'h3f} : r[71:48];
      ecnt = ecnt + 64'h1;
      err_valid <= 1'b1;
      err_for_cmd <= r[57];
      err_source_queue_identifier <= r[15:0];
      err_failing_command_tag <= r[31:16];
      err_status <= r[46:32];
      err_phase <= r[47];
      err_param_byte <= r[53:48];
      err_param_bit <= r[56:54];
      err_vendor_page <= r[71:64];
      err_nsid <= r[103:72];
      err_lba <= r[167:104];
      err_cmd_info <= r[231:168];
      // queue and tag fall back to all ones without a command.
      e.count = ecnt;
      e.sqid = r[57] ? r[15:0] : NO_CMD_ID;
      e.tag = r[57] ? r[31:16] : NO_CMD_ID;
      // status above, phase in bit zero.
      e.status = {r[46:32], r[47]};
      // byte in 7:0, bit in 10:8, else all ones.
      e.pel = r[57] ? {PEL_RSVD, r[56:54], 2'b0, r[53:48]} : 16'hffff;
      e.lba = r[167:104];
      e.nsid = r[103:72];
      // vendor pages below the valid range read as none.
      e.vpage = (r[71:64] >= VPAGE_MIN) ? r[71:64] : VPAGE_NONE;
      e.cmdinfo = r[231:168];
      q.push_front(e);
      @(posedge aclk);
    end
    err_valid <= 1'b0;
    #1;
    `CHK(persist_count, ecnt)
    @(posedge aclk);
  endtask : add_errs

  initial begin
    aresetn = 1'b0;
    {err_valid, err_for_cmd, err_phase, err_status, err_param_byte, err_param_bit} = '0;
    {err_source_queue_identifier, err_failing_command_tag, err_lba, err_nsid} = '0;
    {err_vendor_page, err_cmd_info, crit_warn} = '0;
    // The count keeper restores zero so the first entry is numbered one.
    count_restore = 1'b1;
    count_restore_value = 64'h0;
    ecnt = 64'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    count_restore <= 1'b0;
    @(posedge aclk);
    check_log();
    rchk(8'h30, 32'h0, RESP_SLVERR);
    wreg(8'h34, 32'h1, RESP_SLVERR);
    rchk(A_LOG_ATTR, 32'h0);
    add_errs(3);
    check_log();
    add_errs(DEPTH + 2);
    check_log();
    // Restored count crosses the 32-bit word boundary, then survives a reset.
    count_restore <= 1'b1;
    count_restore_value <= 64'hffff_fffe;
    ecnt = 64'hffff_fffe;
    @(posedge aclk);
    count_restore <= 1'b0;
    add_errs(3);
    check_log();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    q.delete();
    @(posedge aclk);
    `CHK(persist_count, ecnt)
    rchk(A_LIFE_LO, ecnt[31:0]);
    rchk(A_LIFE_HI, ecnt[63:32]);
    check_log();
    add_errs(1);
    check_log();
    // Health requests; the last one runs with aborting switched off.
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        wreg(A_CTRL, 32'h0);
      end
      wreg(A_HEALTH_NSID, hn[i]);
      rchk(A_HEALTH_RESULT, hr[i]);
    end
    // Warnings: bits 0 and 2 enabled, bit 1 masked.
    wreg(A_WARN_EN, 32'h5);
    crit_warn <= 8'h07;
    @(posedge aclk);
    #1;
    `CHK(async_event, 1'b1)
    @(posedge aclk);
    #1;
    `CHK(async_event, 1'b0)
    rchk(A_WARN_FLAGS, 32'h5);
    wreg(A_WARN_FLAGS, 32'h5);
    rchk(A_WARN_FLAGS, 32'h0);
    crit_warn <= 8'h0;
    @(posedge aclk);
    crit_warn <= 8'h02;
    repeat (2) @(posedge aclk);
    #1;
    `CHK(async_event, 1'b0)
    rchk(A_WARN_FLAGS, 32'h0);
    end_of_test();
  end
endmodule : testbench
